/* csrc_pkg.sv */
// Constants, field layouts and carrier types for the character shift,
// rotate and compare unit. Assumes 25-bit words, bit 25 (index 24) the sign.
package csrc_pkg;

  localparam int unsigned WORD_W   = 25;
  localparam int unsigned MAG_W    = 24;
  localparam int unsigned SIGN_POS = 24;
  localparam int unsigned CHAR_W   = 6;
  localparam int unsigned CNT_W    = 10;
  localparam int unsigned NUM_AR   = 4;
  localparam int unsigned IDX_W    = 2;
  localparam int unsigned LAT_W    = 3;

  // Operation codes, octal as printed: 43, 44, 54, 55, 56, 57
  localparam logic [5:0] OP_CHAR_SHL     = 6'h23;
  localparam logic [5:0] OP_BIT_ROR      = 6'h24;
  localparam logic [5:0] OP_CMP_ALG      = 6'h2c;
  localparam logic [5:0] OP_CMP_ABS      = 6'h2d;
  localparam logic [5:0] OP_CMP_ZEROS    = 6'h2e;
  localparam logic [5:0] OP_CMP_CONTAIN  = 6'h2f;

  // Cycle counts per operation
  localparam logic [LAT_W-1:0] LAT_SHL   = 3'h3;
  localparam logic [LAT_W-1:0] LAT_ROT   = 3'h4;
  localparam logic [LAT_W-1:0] LAT_CMP   = 3'h2;
  localparam logic [LAT_W-1:0] LAT_OTHER = 3'h2;
  localparam logic [LAT_W-1:0] LAT_LAST  = 3'h1;
  localparam logic [LAT_W-1:0] LAT_ONE   = 3'h1;

  localparam logic [CNT_W-1:0] CHARS_1W  = 10'h004;
  localparam logic [CNT_W-1:0] CHARS_2W  = 10'h008;
  localparam logic [CNT_W-1:0] ROT_MAX   = 10'h019;
  localparam logic [CNT_W-1:0] ROT_MOD   = 10'h019;

  localparam logic [WORD_W-1:0] WORD_RST = 25'h0000000;

  // Instruction word, bits 25..1 mapped onto [24:0]
  typedef struct packed {
    logic             ind;
    logic [3:0]       xreg;
    logic [5:0]       opcode;
    logic [3:0]       accumulator_select;
    logic [CNT_W-1:0] cnt;
  } csrc_instr_t;

  typedef struct packed {
    logic [WORD_W-1:0] hi;
    logic [WORD_W-1:0] lo;
  } csrc_dword_t;

  typedef struct packed {
    logic gt;
    logic lt;
    logic eq;
  } csrc_ind_t;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_EXEC = 1'b1
  } csrc_state_t;

endpackage

/* csrc_ar_file.sv */
// Four arithmetic registers with two registered read ports and two write
// ports. Assumes one clock; port B wins a same-index write collision.
`timescale 1ns/100ps
`default_nettype none

module csrc_ar_file (
  // Clock and reset
  input  wire logic                            sys_clk,
  input  wire logic                            sys_rst,
  // Read ports
  input  wire logic [csrc_pkg::IDX_W-1:0]      rd_a_idx,
  input  wire logic [csrc_pkg::IDX_W-1:0]      rd_b_idx,
  output logic      [csrc_pkg::WORD_W-1:0]     rd_a_data_ff,
  output logic      [csrc_pkg::WORD_W-1:0]     rd_b_data_ff,
  // Write ports
  input  wire logic                            wr_a_en,
  input  wire logic [csrc_pkg::IDX_W-1:0]      wr_a_idx,
  input  wire logic [csrc_pkg::WORD_W-1:0]     wr_a_data,
  input  wire logic                            wr_b_en,
  input  wire logic [csrc_pkg::IDX_W-1:0]      wr_b_idx,
  input  wire logic [csrc_pkg::WORD_W-1:0]     wr_b_data
);

  logic [csrc_pkg::WORD_W-1:0] mem_ff [csrc_pkg::NUM_AR];

  genvar gi;
  generate
    for (gi = 0; gi < csrc_pkg::NUM_AR; gi++) begin : g_reg
      always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
          mem_ff[gi] <= csrc_pkg::WORD_RST;
        end else if (wr_b_en && (wr_b_idx == gi[csrc_pkg::IDX_W-1:0])) begin
          mem_ff[gi] <= wr_b_data;
        end else if (wr_a_en && (wr_a_idx == gi[csrc_pkg::IDX_W-1:0])) begin
          mem_ff[gi] <= wr_a_data;
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_a_data_ff <= csrc_pkg::WORD_RST;
      rd_b_data_ff <= csrc_pkg::WORD_RST;
    end else begin
      rd_a_data_ff <= mem_ff[rd_a_idx];
      rd_b_data_ff <= mem_ff[rd_b_idx];
    end
  end

endmodule

`default_nettype wire

/* csrc_unit.sv */
// Execution unit for character left shift, bit rotate right and the four
// memory-operand comparisons. Assumes the sequencer has already resolved
// indirect addressing and supplies the fetched memory operand with the
// instruction; all inputs are on sys_clk.
`timescale 1ns/100ps
`default_nettype none

module csrc_unit (
  // Clock and reset
  input  wire logic                                sys_clk,
  input  wire logic                                sys_rst,
  // Instruction from sequencer
  input  wire logic                                instr_valid,
  input  wire logic [csrc_pkg::WORD_W-1:0]         instr_word,
  input  wire csrc_pkg::csrc_dword_t               mem_opnd,
  input  wire logic                                fs_en,
  input  wire csrc_pkg::csrc_dword_t               fs_mask,
  // Register load and readback
  input  wire logic                                ext_wr_en,
  input  wire logic [csrc_pkg::IDX_W-1:0]          ext_wr_idx,
  input  wire logic [csrc_pkg::WORD_W-1:0]         ext_wr_data,
  input  wire logic [csrc_pkg::IDX_W-1:0]          ext_rd_idx,
  output logic      [csrc_pkg::WORD_W-1:0]         ar_rd_data_ff,
  // Status
  output logic                                     busy_ff,
  output logic                                     done_ff,
  output csrc_pkg::csrc_ind_t                      ind_ff,
  output logic                                     parity_err_ff,
  output logic                                     rot_err_ff,
  output logic                                     op_err_ff,
  output logic                                     err_irq_ff
);

  // Number of registers named by the positional field
  function automatic logic [2:0] ar_count(input logic [3:0] sel);
    ar_count = {2'b00, sel[0]} + {2'b00, sel[1]} + {2'b00, sel[2]} + {2'b00, sel[3]};
  endfunction

  // Highest-numbered register named: carries the high-order characters
  function automatic logic [csrc_pkg::IDX_W-1:0] ar_hi_idx(input logic [3:0] sel);
    ar_hi_idx = sel[3] ? 2'h3 : (sel[2] ? 2'h2 : (sel[1] ? 2'h1 : 2'h0));
  endfunction

  function automatic logic [csrc_pkg::IDX_W-1:0] ar_lo_idx(input logic [3:0] sel);
    ar_lo_idx = sel[0] ? 2'h0 : (sel[1] ? 2'h1 : (sel[2] ? 2'h2 : 2'h3));
  endfunction

  function automatic logic [csrc_pkg::LAT_W-1:0] lat_of(input logic [5:0] op);
    case (op)
      csrc_pkg::OP_CHAR_SHL:    lat_of = csrc_pkg::LAT_SHL;
      csrc_pkg::OP_BIT_ROR:     lat_of = csrc_pkg::LAT_ROT;
      csrc_pkg::OP_CMP_ALG,
      csrc_pkg::OP_CMP_ABS,
      csrc_pkg::OP_CMP_ZEROS,
      csrc_pkg::OP_CMP_CONTAIN: lat_of = csrc_pkg::LAT_CMP;
      default:                  lat_of = csrc_pkg::LAT_OTHER;
    endcase
  endfunction

  // Strip both signs; single-word operands use the low word only
  function automatic logic [2*csrc_pkg::MAG_W-1:0] mag_of(input csrc_pkg::csrc_dword_t d,
                                                         input logic two);
    if (two) begin
      mag_of = {d.hi[csrc_pkg::MAG_W-1:0], d.lo[csrc_pkg::MAG_W-1:0]};
    end else begin
      mag_of = {{csrc_pkg::MAG_W{1'b0}}, d.lo[csrc_pkg::MAG_W-1:0]};
    end
  endfunction

  csrc_pkg::csrc_state_t  state_ff;
  csrc_pkg::csrc_instr_t  op_ff;
  csrc_pkg::csrc_instr_t  instr_in;
  csrc_pkg::csrc_dword_t  opnd_ff;
  csrc_pkg::csrc_dword_t  mask_ff;
  logic [csrc_pkg::LAT_W-1:0] lat_ff;
  logic [csrc_pkg::IDX_W-1:0] hi_idx_ff;
  logic [csrc_pkg::IDX_W-1:0] lo_idx_ff;
  logic                       two_ff;
  logic                       sel_bad_ff;
  logic                       rd_ext_ff;

  logic                       accept;
  logic                       commit;
  logic [csrc_pkg::IDX_W-1:0] rd_a_idx;
  logic [csrc_pkg::IDX_W-1:0] rd_b_idx;
  logic [csrc_pkg::WORD_W-1:0] rd_a_data;
  logic [csrc_pkg::WORD_W-1:0] rd_b_data;

  assign instr_in = csrc_pkg::csrc_instr_t'(instr_word);
  assign accept   = instr_valid && (state_ff == csrc_pkg::ST_IDLE);
  assign commit   = (state_ff == csrc_pkg::ST_EXEC) && (lat_ff == csrc_pkg::LAT_LAST);

  // Operand reads start in the accept cycle so data is ready one edge later
  always_comb begin
    if (state_ff == csrc_pkg::ST_EXEC) begin
      rd_a_idx = hi_idx_ff;
      rd_b_idx = lo_idx_ff;
    end else if (instr_valid) begin
      rd_a_idx = ar_hi_idx(instr_in.accumulator_select);
      rd_b_idx = ar_lo_idx(instr_in.accumulator_select);
    end else begin
      rd_a_idx = ext_rd_idx;
      rd_b_idx = ext_rd_idx;
    end
  end

  // Sequencing
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff <= csrc_pkg::ST_IDLE;
      lat_ff   <= csrc_pkg::LAT_ONE;
      busy_ff  <= 1'b0;
      done_ff  <= 1'b0;
    end else begin
      done_ff <= commit;
      case (state_ff)
        csrc_pkg::ST_IDLE: begin
          if (accept) begin
            state_ff <= csrc_pkg::ST_EXEC;
            lat_ff   <= lat_of(instr_in.opcode);
            busy_ff  <= 1'b1;
          end
        end
        csrc_pkg::ST_EXEC: begin
          if (commit) begin
            state_ff <= csrc_pkg::ST_IDLE;
            busy_ff  <= 1'b0;
          end else begin
            lat_ff <= lat_ff - csrc_pkg::LAT_ONE;
          end
        end
        default: begin
          state_ff <= csrc_pkg::ST_IDLE;
          busy_ff  <= 1'b0;
        end
      endcase
    end
  end

  // Latched instruction and operand selection
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      op_ff      <= '0;
      opnd_ff    <= '0;
      mask_ff    <= '0;
      hi_idx_ff  <= '0;
      lo_idx_ff  <= '0;
      two_ff     <= 1'b0;
      sel_bad_ff <= 1'b0;
    end else if (accept) begin
      op_ff      <= instr_in;
      opnd_ff    <= mem_opnd;
      // Selection narrows only comparisons; shifts see the whole word
      mask_ff    <= fs_en ? fs_mask : '1;
      hi_idx_ff  <= ar_hi_idx(instr_in.accumulator_select);
      lo_idx_ff  <= ar_lo_idx(instr_in.accumulator_select);
      two_ff     <= (ar_count(instr_in.accumulator_select) == 3'h2);
      sel_bad_ff <= (ar_count(instr_in.accumulator_select) == 3'h0) ||
                    (ar_count(instr_in.accumulator_select) > 3'h2);
    end
  end

  // Character left shift over one or two words
  logic [2*csrc_pkg::MAG_W-1:0] shl_src;
  logic [2*csrc_pkg::MAG_W-1:0] shl_res;
  logic [5:0]                   shl_amt;
  logic                         shl_err;

  // Higher-numbered register is the high word; the program keeps it so
  assign shl_src = mag_of('{hi: rd_a_data, lo: rd_b_data}, two_ff);
  assign shl_amt = 6'(op_ff.cnt[2:0] * csrc_pkg::CHAR_W);
  // Counts past the operand leave nothing but fill characters
  assign shl_res = (op_ff.cnt >= csrc_pkg::CHARS_2W) ? '0 : (shl_src << shl_amt);
  assign shl_err = op_ff.cnt > (two_ff ? csrc_pkg::CHARS_2W : csrc_pkg::CHARS_1W);

  logic [csrc_pkg::WORD_W-1:0] shl_hi;
  logic [csrc_pkg::WORD_W-1:0] shl_lo;

  assign shl_hi = {rd_a_data[csrc_pkg::SIGN_POS], shl_res[2*csrc_pkg::MAG_W-1:csrc_pkg::MAG_W]};
  assign shl_lo = {rd_b_data[csrc_pkg::SIGN_POS], shl_res[csrc_pkg::MAG_W-1:0]};

  // Bit rotate right; counts above the word length wrap modulo the length
  logic [4:0]                    rot_amt;
  logic [2*csrc_pkg::WORD_W-1:0] rot_dbl;
  logic [csrc_pkg::WORD_W-1:0]   rot_res;
  logic                          rot_err;

  assign rot_amt = 5'(op_ff.cnt % csrc_pkg::ROT_MOD);
  assign rot_dbl = {rd_b_data, rd_b_data} >> rot_amt;
  assign rot_res = rot_dbl[csrc_pkg::WORD_W-1:0];
  assign rot_err = (op_ff.cnt > csrc_pkg::ROT_MAX) || two_ff;

  // Comparisons, all on masked copies so operands are never rewritten
  csrc_pkg::csrc_dword_t        reg_v;
  csrc_pkg::csrc_dword_t        mem_v;
  logic [2*csrc_pkg::MAG_W-1:0] reg_mag;
  logic [2*csrc_pkg::MAG_W-1:0] mem_mag;
  logic                         reg_neg;
  logic                         mem_neg;
  logic [2*csrc_pkg::WORD_W-1:0] contain_miss;
  logic [2*csrc_pkg::WORD_W-1:0] zero_miss;
  csrc_pkg::csrc_ind_t          cmp_res;

  always_comb begin
    reg_v.hi = two_ff ? (rd_a_data & mask_ff.hi) : csrc_pkg::WORD_RST;
    reg_v.lo = rd_b_data & mask_ff.lo;
    mem_v.hi = two_ff ? (opnd_ff.hi & mask_ff.hi) : csrc_pkg::WORD_RST;
    mem_v.lo = opnd_ff.lo & mask_ff.lo;
  end

  assign reg_mag      = mag_of(reg_v, two_ff);
  assign mem_mag      = mag_of(mem_v, two_ff);
  assign reg_neg      = reg_v.lo[csrc_pkg::SIGN_POS];
  assign mem_neg      = mem_v.lo[csrc_pkg::SIGN_POS];
  assign contain_miss = reg_v & ~mem_v;
  assign zero_miss    = reg_v & mem_v;

  always_comb begin
    cmp_res = '0;
    case (op_ff.opcode)
      csrc_pkg::OP_CMP_ABS: begin
        cmp_res.gt = reg_mag > mem_mag;
        cmp_res.lt = reg_mag < mem_mag;
        cmp_res.eq = reg_mag == mem_mag;
      end
      csrc_pkg::OP_CMP_ALG: begin
        if (reg_neg != mem_neg) begin
          // Sign alone decides, so plus zero beats minus zero
          cmp_res.gt = !reg_neg;
          cmp_res.lt = reg_neg;
        end else if (!reg_neg) begin
          cmp_res.gt = reg_mag > mem_mag;
          cmp_res.lt = reg_mag < mem_mag;
          cmp_res.eq = reg_mag == mem_mag;
        end else begin
          cmp_res.gt = reg_mag < mem_mag;
          cmp_res.lt = reg_mag > mem_mag;
          cmp_res.eq = reg_mag == mem_mag;
        end
      end
      csrc_pkg::OP_CMP_CONTAIN: begin
        cmp_res.eq = (contain_miss == '0);
        cmp_res.gt = (contain_miss != '0);
      end
      csrc_pkg::OP_CMP_ZEROS: begin
        cmp_res.eq = (zero_miss == '0);
        cmp_res.gt = (zero_miss != '0);
      end
      default: cmp_res = '0;
    endcase
  end

  logic is_cmp;
  assign is_cmp = (op_ff.opcode == csrc_pkg::OP_CMP_ABS) || (op_ff.opcode == csrc_pkg::OP_CMP_ALG) ||
                  (op_ff.opcode == csrc_pkg::OP_CMP_CONTAIN) || (op_ff.opcode == csrc_pkg::OP_CMP_ZEROS);

  // Indicators persist; only a completed comparison replaces them
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ind_ff <= '0;
    end else if (commit && is_cmp && !sel_bad_ff) begin
      ind_ff <= cmp_res;
    end
  end

  // Write-back: port A serves register loads while idle
  logic                        wr_a_en;
  logic [csrc_pkg::IDX_W-1:0]  wr_a_idx;
  logic [csrc_pkg::WORD_W-1:0] wr_a_data;
  logic                        wr_b_en;
  logic                        shl_wb;
  logic                        rot_wb;

  assign shl_wb = commit && (op_ff.opcode == csrc_pkg::OP_CHAR_SHL) && !sel_bad_ff;
  assign rot_wb = commit && (op_ff.opcode == csrc_pkg::OP_BIT_ROR) && !sel_bad_ff && !two_ff;

  always_comb begin
    if (shl_wb) begin
      wr_a_en   = 1'b1;
      wr_a_idx  = lo_idx_ff;
      wr_a_data = shl_lo;
    end else if (rot_wb) begin
      wr_a_en   = 1'b1;
      wr_a_idx  = lo_idx_ff;
      wr_a_data = rot_res;
    end else begin
      wr_a_en   = ext_wr_en && (state_ff == csrc_pkg::ST_IDLE) && !instr_valid;
      wr_a_idx  = ext_wr_idx;
      wr_a_data = ext_wr_data;
    end
  end

  assign wr_b_en = shl_wb && two_ff;

  csrc_ar_file u_ar_file (
    .sys_clk      (sys_clk),
    .sys_rst      (sys_rst),
    .rd_a_idx     (rd_a_idx),
    .rd_b_idx     (rd_b_idx),
    .rd_a_data_ff (rd_a_data),
    .rd_b_data_ff (rd_b_data),
    .wr_a_en      (wr_a_en),
    .wr_a_idx     (wr_a_idx),
    .wr_a_data    (wr_a_data),
    .wr_b_en      (wr_b_en),
    .wr_b_idx     (hi_idx_ff),
    .wr_b_data    (shl_hi)
  );

  // Error reporting; the oversize shift still writes its result
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      parity_err_ff <= 1'b0;
      rot_err_ff    <= 1'b0;
      op_err_ff     <= 1'b0;
      err_irq_ff    <= 1'b0;
    end else begin
      parity_err_ff <= shl_wb && shl_err;
      rot_err_ff    <= commit && (op_ff.opcode == csrc_pkg::OP_BIT_ROR) && rot_err;
      op_err_ff     <= commit && (sel_bad_ff ||
                                  (!is_cmp && (op_ff.opcode != csrc_pkg::OP_CHAR_SHL) &&
                                   (op_ff.opcode != csrc_pkg::OP_BIT_ROR)));
      err_irq_ff    <= shl_wb && shl_err;
    end
  end

  // Readback of a register, two cycles after its index is presented
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_ext_ff     <= 1'b0;
      ar_rd_data_ff <= csrc_pkg::WORD_RST;
    end else begin
      rd_ext_ff <= (state_ff == csrc_pkg::ST_IDLE) && !instr_valid;
      if (rd_ext_ff) begin
        ar_rd_data_ff <= rd_a_data;
      end
    end
  end

endmodule

`default_nettype wire

/* csrc_unit_props.sv */
// Checker for csrc_unit: latencies, error pulses and comparison indicators.
// Assumes only the unit's ports; the running opcode is tracked locally.
`timescale 1ns/100ps
`default_nettype none

module csrc_unit_props (
  // Clock and reset
  input wire logic                        sys_clk,
  input wire logic                        sys_rst,
  // Instruction
  input wire logic                        instr_valid,
  input wire logic [csrc_pkg::WORD_W-1:0] instr_word,
  // Status
  input wire logic                        busy_ff,
  input wire logic                        done_ff,
  input wire csrc_pkg::csrc_ind_t         ind_ff,
  input wire logic                        parity_err_ff,
  input wire logic                        rot_err_ff,
  input wire logic                        op_err_ff,
  input wire logic                        err_irq_ff
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  logic [5:0] op_ff;
  logic       bitcmp;
  logic       anycmp;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      op_ff <= 6'h00;
    end else if (instr_valid && !busy_ff) begin
      op_ff <= instr_word[19:14];
    end
  end

  assign bitcmp = (op_ff == csrc_pkg::OP_CMP_ZEROS) || (op_ff == csrc_pkg::OP_CMP_CONTAIN);
  assign anycmp = bitcmp || (op_ff == csrc_pkg::OP_CMP_ABS) || (op_ff == csrc_pkg::OP_CMP_ALG);

  sequence s_take(logic [5:0] op);
    instr_valid && !busy_ff && (instr_word[19:14] == op);
  endsequence

  sequence s_finish;
    done_ff && !busy_ff;
  endsequence

  AST_SHL_LAT: assert property (s_take(csrc_pkg::OP_CHAR_SHL) |=> busy_ff[*3] ##1 s_finish)
    else $error("char shift latency wrong");
  AST_ROT_LAT: assert property (s_take(csrc_pkg::OP_BIT_ROR) |=> busy_ff[*4] ##1 s_finish)
    else $error("rotate latency wrong");
  AST_CMP_LAT: assert property ((s_take(csrc_pkg::OP_CMP_ABS) or s_take(csrc_pkg::OP_CMP_ALG)) |=> busy_ff[*2] ##1 s_finish)
    else $error("compare latency wrong");
  AST_IND_SET: assert property (done_ff && anycmp && !op_err_ff |-> $onehot(ind_ff))
    else $error("indicators not one-hot after compare");
  AST_BITCMP: assert property (done_ff && bitcmp && !op_err_ff |-> !ind_ff.lt)
    else $error("bit compare set less");
  AST_IND_HOLD: assert property (!(done_ff && anycmp && !op_err_ff) |-> $stable(ind_ff))
    else $error("indicators moved without a compare");
  AST_PAR_IRQ: assert property ((parity_err_ff || err_irq_ff) |-> parity_err_ff && err_irq_ff && done_ff && op_ff == csrc_pkg::OP_CHAR_SHL)
    else $error("parity error and interrupt not paired");
  AST_ROT_ERR: assert property (rot_err_ff |-> done_ff && op_ff == csrc_pkg::OP_BIT_ROR)
    else $error("rotate error outside rotate");
endmodule

bind csrc_unit csrc_unit_props u_csrc_unit_props (.sys_clk, .sys_rst, .instr_valid, .instr_word, .busy_ff,
  .done_ff, .ind_ff, .parity_err_ff, .rot_err_ff, .op_err_ff, .err_irq_ff);

`default_nettype wire

/* csrc_seq_model.sv */
// Sequencer and memory model offering one instruction at a time.
// Assumes sys_clk; requests launch 1 ns after a rising edge.
`timescale 1ns/100ps
`default_nettype none

module csrc_seq_model (
  // Clock
  input  wire logic                   sys_clk,
  // Instruction handshake
  input  wire logic                   busy_ff,
  output logic                        instr_valid,
  output logic [24:0]                 instr_word,
  output csrc_pkg::csrc_dword_t       mem_opnd,
  output logic                        fs_en,
  output csrc_pkg::csrc_dword_t       fs_mask
);
  initial begin
    instr_valid = 1'b0;
    instr_word  = 25'h0000000;
    mem_opnd    = 50'h0;
    fs_en       = 1'b0;
    fs_mask     = 50'h0;
  end

  // Gap models a slow sequencer; released lines are inverted so stale data never matches
  task automatic issue(input logic [24:0] w, input logic [49:0] m, input logic f,
                       input logic [49:0] k, input int gap, output logic ok);
    logic taken;
    int   n;
    repeat (gap + 1) @(posedge sys_clk);
    #1;
    instr_valid = 1'b1;
    instr_word  = w;
    mem_opnd    = m;
    fs_en       = f;
    fs_mask     = k;
    ok          = 1'b0;
    for (n = 0; n < 50; n++) begin
      taken = !busy_ff;
      @(posedge sys_clk);
      #1;
      if (taken) begin
        ok = 1'b1;
        break;
      end
    end
    instr_valid = 1'b0;
    instr_word  = ~w;
    mem_opnd    = ~m;
    fs_en       = ~f;
    fs_mask     = ~k;
  endtask
endmodule

`default_nettype wire

/* tb_top.sv */
// Self-checking bench for csrc_unit: shifts, rotates, compares and errors.
// Assumes csrc_seq_model feeds instructions; registers load through ext ports.
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  logic                  sys_clk;
  logic                  sys_rst;
  logic                  instr_valid;
  logic [24:0]           instr_word;
  csrc_pkg::csrc_dword_t mem_opnd;
  logic                  fs_en;
  csrc_pkg::csrc_dword_t fs_mask;
  logic                  ext_wr_en;
  logic [1:0]            ext_wr_idx;
  logic [24:0]           ext_wr_data;
  logic [1:0]            ext_rd_idx;
  logic [24:0]           ar_rd_data_ff;
  logic                  busy_ff;
  logic                  done_ff;
  csrc_pkg::csrc_ind_t   ind_ff;
  logic                  parity_err_ff;
  logic                  rot_err_ff;
  logic                  op_err_ff;
  logic                  err_irq_ff;
  int                    bad_count;
  int                    compares;

  csrc_unit u_csrc_unit (.sys_clk, .sys_rst, .instr_valid, .instr_word, .mem_opnd, .fs_en, .fs_mask,
    .ext_wr_en, .ext_wr_idx, .ext_wr_data, .ext_rd_idx, .ar_rd_data_ff, .busy_ff, .done_ff, .ind_ff,
    .parity_err_ff, .rot_err_ff, .op_err_ff, .err_irq_ff);
  csrc_seq_model u_csrc_seq_model (.sys_clk, .busy_ff, .instr_valid, .instr_word, .mem_opnd, .fs_en, .fs_mask);

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic test_done();
    if (bad_count == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [24:0] g, input logic [24:0] e);
    compares++;
    if (g !== e) begin
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
      bad_count++;
    end
  endtask

  function automatic logic [24:0] mk(input logic [5:0] op, input logic [3:0] ar, input logic [9:0] c);
    mk = {1'b0, 4'h0, op, ar, c};
  endfunction

  task automatic ld(input logic [1:0] i, input logic [24:0] d);
    @(posedge sys_clk);
    #1;
    ext_wr_en   = 1'b1;
    ext_wr_idx  = i;
    ext_wr_data = d;
    @(posedge sys_clk);
    #1;
    ext_wr_en = 1'b0;
  endtask

  task automatic rd(input logic [1:0] i, input logic [24:0] e);
    ext_rd_idx = i;
    repeat (3) @(posedge sys_clk);
    #1;
    chk(ar_rd_data_ff, e);
  endtask

  task automatic run(input logic [24:0] w, input logic [49:0] m, input logic f, input logic [49:0] k,
                     input int gap, input logic [2:0] n_exp, input logic [3:0] e_err);
    logic ok;
    int   n;
    u_csrc_seq_model.issue(w, m, f, k, gap, ok);
    for (n = 1; n <= 20 && ok; n++) begin
      @(posedge sys_clk);
      #1;
      if (done_ff === 1'b1) begin
        break;
      end
    end
    if (!ok || n > 20) begin
      bad_count++;
      test_done();
    end
    chk(25'(n), {22'h0, n_exp});
    chk({21'h0, parity_err_ff, err_irq_ff, rot_err_ff, op_err_ff}, {21'h0, e_err});
  endtask

  task automatic cmp(input logic [5:0] op, input logic [24:0] rv, input logic [24:0] mv,
                     input logic [24:0] k, input logic [2:0] e);
    ld(2'h0, rv);
    run(mk(op, 4'b0001, 10'h000), {25'h0, mv}, |k, {25'h0, k}, 0, 3'h2, 4'h0);
    chk({22'h0, ind_ff}, {22'h0, e});
    rd(2'h0, rv);
  endtask

  task automatic t_shift_one();
    ld(2'h1, 25'h1123456);
    ld(2'h0, 25'h0abcdef);
    run(mk(csrc_pkg::OP_CHAR_SHL, 4'b0010, 10'h002), 50'h0, 1'b1, 50'h0, 0, 3'h3, 4'h0);
    rd(2'h1, 25'h1456000);
    rd(2'h0, 25'h0abcdef);
  endtask

  task automatic t_shift_two();
    ld(2'h0, 25'h1abcdef);
    ld(2'h2, 25'h0123456);
    ld(2'h1, 25'h0555555);
    // Low register feeds the higher one only
    run(mk(csrc_pkg::OP_CHAR_SHL, 4'b0101, 10'h001), 50'h0, 1'b0, 50'h0, 2, 3'h3, 4'h0);
    rd(2'h2, 25'h08d15aa);
    rd(2'h0, 25'h1f37bc0);
    rd(2'h1, 25'h0555555);
  endtask

  task automatic t_shift_over();
    ld(2'h3, 25'h1ffffff);
    run(mk(csrc_pkg::OP_CHAR_SHL, 4'b1000, 10'h005), 50'h0, 1'b0, 50'h0, 0, 3'h3, 4'b1100);
    rd(2'h3, 25'h1000000);
  endtask

  task automatic t_rotate();
    ld(2'h3, 25'h0000003);
    run(mk(csrc_pkg::OP_BIT_ROR, 4'b1000, 10'h010), 50'h0, 1'b1, 50'h0, 0, 3'h4, 4'h0);
    rd(2'h3, 25'h0000600);
    ld(2'h3, 25'h0000001);
    run(mk(csrc_pkg::OP_BIT_ROR, 4'b1000, 10'h001), 50'h0, 1'b0, 50'h0, 1, 3'h4, 4'h0);
    rd(2'h3, 25'h1000000);
    run(mk(csrc_pkg::OP_BIT_ROR, 4'b1000, 10'h01a), 50'h0, 1'b0, 50'h0, 3, 3'h4, 4'b0010);
    rd(2'h3, 25'h0800000);
    run(mk(csrc_pkg::OP_BIT_ROR, 4'b1001, 10'h001), 50'h0, 1'b0, 50'h0, 0, 3'h4, 4'b0010);
    rd(2'h3, 25'h0800000);
  endtask

  task automatic t_compare();
    cmp(csrc_pkg::OP_CMP_ABS, 25'h1000005, 25'h0000003, 25'h0, 3'b100);
    cmp(csrc_pkg::OP_CMP_ABS, 25'h0000003, 25'h1000005, 25'h0, 3'b010);
    cmp(csrc_pkg::OP_CMP_ALG, 25'h0000000, 25'h1000000, 25'h0, 3'b100);
    cmp(csrc_pkg::OP_CMP_ALG, 25'h1000005, 25'h0000003, 25'h0, 3'b010);
    cmp(csrc_pkg::OP_CMP_ALG, 25'h0000007, 25'h0000007, 25'h0, 3'b001);
    cmp(csrc_pkg::OP_CMP_CONTAIN, 25'h1000001, 25'h0ffffff, 25'h0, 3'b100);
    cmp(csrc_pkg::OP_CMP_CONTAIN, 25'h1000001, 25'h1ffffff, 25'h0, 3'b001);
    cmp(csrc_pkg::OP_CMP_ZEROS, 25'h0000002, 25'h0000003, 25'h0, 3'b100);
    cmp(csrc_pkg::OP_CMP_ZEROS, 25'h1000000, 25'h0ffffff, 25'h0, 3'b001);
    cmp(csrc_pkg::OP_CMP_ABS, 25'h0000005, 25'h0000003, 25'h0000001, 3'b001);
  endtask

  task automatic t_cmp_two();
    ld(2'h0, 25'h0000001);
    ld(2'h1, 25'h1000000);
    run(mk(csrc_pkg::OP_CMP_ALG, 4'b0011, 10'h000), 50'h0, 1'b0, 50'h0, 0, 3'h2, 4'h0);
    chk({22'h0, ind_ff}, {22'h0, 3'b100});
  endtask

  task automatic t_bad_sel();
    run(mk(csrc_pkg::OP_CMP_ABS, 4'b0000, 10'h000), 50'h0, 1'b0, 50'h0, 0, 3'h2, 4'b0001);
    run(mk(csrc_pkg::OP_CMP_ALG, 4'b0111, 10'h000), 50'h0, 1'b0, 50'h0, 0, 3'h2, 4'b0001);
    run(mk(6'h30, 4'b0001, 10'h000), 50'h0, 1'b0, 50'h0, 0, 3'h2, 4'b0001);
    chk({22'h0, ind_ff}, {22'h0, 3'b100});
  endtask

  initial begin
    bad_count   = 0;
    compares    = 0;
    sys_rst     = 1'b1;
    ext_wr_en   = 1'b0;
    ext_wr_idx  = 2'h0;
    ext_wr_data = 25'h0000000;
    ext_rd_idx  = 2'h0;
    repeat (5) @(posedge sys_clk);
    #1;
    sys_rst = 1'b0;
    chk({22'h0, ind_ff}, 25'h0);
    t_shift_one();
    t_shift_two();
    t_shift_over();
    t_rotate();
    t_compare();
    t_cmp_two();
    t_bad_sel();
    test_done();
  end
endmodule

`default_nettype wire
